// ---- rtl/sensor_duty_pkg.sv ----
// constants, tables and carrier types of the duty-cycle power controller
package sensor_duty_pkg;

  // =========================================================================
  // clock and bus
  localparam int unsigned CLK_MHZ    = 200;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned DATA_W     = 32;

  // =========================================================================
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CHAN    = 8'h02;
  localparam logic [7:0] IDX_MODE    = 8'h27;
  localparam logic [7:0] IDX_STATUS  = 8'h28;
  localparam logic [7:0] IDX_MASK    = 8'h29;
  localparam logic [7:0] IDX_THRESH  = 8'h2A;
  localparam logic [7:0] IDX_DATA_X  = 8'h2B;
  localparam logic [7:0] IDX_DATA_Y  = 8'h2C;
  localparam logic [7:0] IDX_DATA_Z  = 8'h2D;
  localparam logic [7:0] IDX_CORE    = 8'h2E;

  // =========================================================================
  // field positions
  localparam int unsigned MODE_LSB   = 0;
  localparam int unsigned INACT_LSB  = 4;
  localparam int unsigned BW_LSB     = 0;
  localparam int unsigned CHAN_LSB   = 6;   // x bit 6, y bit 7, z bit 8
  localparam int unsigned ST_UPDATE  = 0;
  localparam int unsigned ST_OVER    = 1;
  localparam int unsigned CORE_FIR   = 2;
  localparam int unsigned CORE_UNDEF = 3;
  localparam logic [2:0]  BW_FIR_MAX = 3'h2;
  localparam logic [2:0]  BW_UNDEF_A = 3'h3;
  localparam logic [2:0]  BW_UNDEF_B = 3'h7;
  localparam logic [2:0]  BW_STANDIN = 3'h6;

  // =========================================================================
  // reset values
  localparam logic [2:0]  CHAN_RESET   = 3'h7;
  localparam logic [2:0]  BW_RESET     = 3'h0;
  localparam logic [2:0]  INACT_RESET  = 3'h0;
  localparam logic [1:0]  STAT_RESET   = 2'h0;
  localparam logic [15:0] THRESH_RESET = 16'h7FFF;

  // =========================================================================
  // modes and phases
  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'h0,
    MODE_SLEEP  = 2'h1,
    MODE_DUTY   = 2'h2
  } mode_type;

  typedef enum logic [1:0] {
    PH_IDLE     = 2'b00,
    PH_ACTIVE   = 2'b01,
    PH_INACTIVE = 2'b11
  } phase_type;

  // =========================================================================
  // timing tables in microseconds
  localparam int unsigned INACTIVE_US [8] = '{500, 1000, 5000, 10000, 50000, 100000, 500000, 1000000};
  // per code: one, two, three channels
  localparam int unsigned ACTIVE_US [8][3] = '{
    '{218, 390, 592}, '{135, 224, 313}, '{114, 141, 188}, '{0, 0, 0},
    '{119, 191, 263}, '{84, 125, 164},  '{69, 91, 114},   '{0, 0, 0}};

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } field_sample_type;

endpackage

// ---- rtl/sensor_duty_ctrl.sv ----
// power mode, conversion scheduling and apb register file of the field sensor
//
// Summary of operation
// - codes 0-2 filtered, 4-6 unfiltered, 3/7 undefined
// - axes enabled independently, all on at reset
// - mode value 2 starts duty-cycle alternation
// - inactive code sets wait; code 0 is 500 us
// - register access served during any phase
// - burst length from bandwidth code and channel count
// - code 0 is slowest, most filtered conversion
// - interrupt when enabled field exceeds threshold
// - mode field: 0 active, 1 sleep, 2 duty
// - eight inactive waits, 0.5 ms to 1000 ms
// - bits 8/7/6 enable z/y/x channels
module sensor_duty_ctrl
  import sensor_duty_pkg::*;
#(
  parameter int unsigned CYCLES_PER_US = CLK_MHZ  // shorten for simulation
) (
  input  wire logic              pclk,     // bus and core clock
  input  wire logic              presetn,  // async reset, active low
  input  wire logic              psel,     // apb select
  input  wire logic              penable,  // apb access phase
  input  wire logic              pwrite,   // apb direction
  input  wire logic [ADDR_W-1:0] paddr,    // apb byte address
  input  wire logic [DATA_W-1:0] pwdata,   // apb write data
  output logic      [DATA_W-1:0] prdata,   // apb read data
  output logic                   pready,   // apb ready
  output logic                   pslverr,  // apb error on unmapped address
  input  wire field_sample_type  field,    // front-end samples, same clock
  output logic                   irq,      // level interrupt, active high
  output logic                   converting // high during active burst
);

  // =========================================================================
  // state
  typedef struct packed {
    logic              ready;
    logic              slverr;
    logic [DATA_W-1:0] rdata;
    mode_type          mode;
    logic [2:0]        inact;
    logic [2:0]        chan;   // z, y, x
    logic [2:0]        bw;
    logic [1:0]        status;
    logic [1:0]        mask;
    logic [15:0]       thresh;
    field_sample_type  data;
    phase_type         phase;
    logic [31:0]       count;
  } state_type;

  state_type st;
  state_type next_st;

  // =========================================================================
  // functions
  function automatic logic [1:0] chan_count(input logic [2:0] en);
    chan_count = {1'b0, en[0]} + {1'b0, en[1]} + {1'b0, en[2]};
  endfunction

  function automatic logic bw_undefined(input logic [2:0] code);
    bw_undefined = (code == BW_UNDEF_A) || (code == BW_UNDEF_B);
  endfunction

  // undefined codes borrow the fastest timing; no channels gives one cycle
  function automatic logic [31:0] burst_cycles(input logic [2:0] code, input logic [2:0] en);
    logic [2:0]  c;
    logic [1:0]  n;
    int unsigned us;
    c  = bw_undefined(code) ? BW_STANDIN : code;
    n  = chan_count(en);
    us = (n == 2'h0) ? 0 : ACTIVE_US[c][n - 2'h1];
    burst_cycles = (us == 0) ? 32'h0 : 32'(us * CYCLES_PER_US - 1);
  endfunction

  function automatic logic [31:0] wait_cycles(input logic [2:0] code);
    wait_cycles = 32'(INACTIVE_US[code] * CYCLES_PER_US - 1);
  endfunction

  function automatic logic [15:0] magnitude(input logic signed [15:0] v);
    magnitude = v[15] ? 16'(-v) : 16'(v);
  endfunction

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    i = a[9:2];
    reg_hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:10] == '0) &&
              (i == IDX_CHAN || i == IDX_MODE || i == IDX_STATUS || i == IDX_MASK ||
               i == IDX_THRESH || i == IDX_DATA_X || i == IDX_DATA_Y || i == IDX_DATA_Z ||
               i == IDX_CORE);
  endfunction

  // =========================================================================
  // combinational next state
  logic              access;
  logic              wr_now;
  logic              run;
  logic              fir;
  logic              over;
  logic [1:0]        stat_set;
  logic [1:0]        stat_clr;
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    next_st  = st;
    access   = psel && penable;
    wr_now   = access && st.ready && pwrite && reg_hit(paddr);
    run      = (st.mode == MODE_ACTIVE) || (st.mode == MODE_DUTY);
    fir      = (st.bw <= BW_FIR_MAX);
    stat_set = '0;
    stat_clr = '0;
    over     = (st.chan[0] && magnitude(field.x) > st.thresh) ||
               (st.chan[1] && magnitude(field.y) > st.thresh) ||
               (st.chan[2] && magnitude(field.z) > st.thresh);
    rd_mux   = '0;
    unique case (paddr[9:2])
      IDX_CHAN:   rd_mux = DATA_W'({st.chan, 3'h0, st.bw}) ;
      IDX_MODE:   rd_mux = DATA_W'({st.inact, 2'h0, st.mode});
      IDX_STATUS: rd_mux = DATA_W'(st.status);
      IDX_MASK:   rd_mux = DATA_W'(st.mask);
      IDX_THRESH: rd_mux = DATA_W'(st.thresh);
      IDX_DATA_X: rd_mux = DATA_W'(unsigned'(st.data.x));
      IDX_DATA_Y: rd_mux = DATA_W'(unsigned'(st.data.y));
      IDX_DATA_Z: rd_mux = DATA_W'(unsigned'(st.data.z));
      IDX_CORE:   rd_mux = DATA_W'({bw_undefined(st.bw), fir, st.phase});
      default:    rd_mux = '0;
    endcase

    // one wait state; slave never depends on the core phase
    if (access && !st.ready) begin
      next_st.ready  = 1'b1;
      next_st.rdata  = reg_hit(paddr) ? rd_mux : '0;
      next_st.slverr = !reg_hit(paddr);
    end else begin
      next_st.ready  = 1'b0;
      next_st.slverr = 1'b0;
    end

    if (wr_now) begin
      unique case (paddr[9:2])
        IDX_CHAN: begin
          next_st.chan = pwdata[CHAN_LSB +: 3];
          next_st.bw   = pwdata[BW_LSB +: 3];
        end
        IDX_MODE: begin
          next_st.mode  = mode_type'(pwdata[MODE_LSB +: 2]);
          next_st.inact = pwdata[INACT_LSB +: 3];
        end
        IDX_STATUS: stat_clr = pwdata[1:0];
        IDX_MASK:   next_st.mask = pwdata[1:0];
        IDX_THRESH: next_st.thresh = pwdata[15:0];
        default: ;
      endcase
    end

    // conversion scheduler
    unique case (st.phase)
      PH_IDLE: begin
        if (run) begin
          next_st.phase = PH_ACTIVE;
          next_st.count = burst_cycles(st.bw, st.chan);
        end
      end
      PH_ACTIVE: begin
        if (!run) begin
          next_st.phase = PH_IDLE;
        end else if (st.count == 32'h0) begin
          if (st.chan[0]) next_st.data.x = field.x;
          if (st.chan[1]) next_st.data.y = field.y;
          if (st.chan[2]) next_st.data.z = field.z;
          stat_set[ST_UPDATE] = 1'b1;
          stat_set[ST_OVER]   = over;
          if (st.mode == MODE_DUTY) begin
            next_st.phase = PH_INACTIVE;
            next_st.count = wait_cycles(st.inact);
          end else begin
            next_st.count = burst_cycles(st.bw, st.chan);
          end
        end else begin
          next_st.count = st.count - 32'h1;
        end
      end
      PH_INACTIVE: begin
        if (!run) begin
          next_st.phase = PH_IDLE;
        end else if (st.count == 32'h0 || st.mode == MODE_ACTIVE) begin
          next_st.phase = PH_ACTIVE;
          next_st.count = burst_cycles(st.bw, st.chan);
        end else begin
          next_st.count = st.count - 32'h1;
        end
      end
      default: next_st.phase = PH_IDLE;
    endcase

    // a set in the same cycle as its clear wins
    next_st.status = (st.status & ~stat_clr) | stat_set;
  end

  // =========================================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st        <= '0;
      st.mode   <= MODE_ACTIVE;
      st.inact  <= INACT_RESET;
      st.chan   <= CHAN_RESET;
      st.bw     <= BW_RESET;
      st.status <= STAT_RESET;
      st.thresh <= THRESH_RESET;
      st.phase  <= PH_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign prdata     = st.rdata;
  assign pready     = st.ready;
  assign pslverr    = st.slverr;
  assign irq        = |(st.status & st.mask);
  assign converting = (st.phase == PH_ACTIVE);

  // =========================================================================
  // helper views of the bus and front-end; only the checks read them
  logic        [2:0]  chan_wdata;
  logic        [1:0]  mode_wdata;
  logic        [2:0]  inact_wdata;
  logic        [7:0]  bus_idx;
  logic               bus_done;
  logic signed [15:0] field_x;

  assign chan_wdata  = pwdata[CHAN_LSB +: 3];
  assign mode_wdata  = pwdata[MODE_LSB +: 2];
  assign inact_wdata = pwdata[INACT_LSB +: 3];
  assign bus_idx     = paddr[9:2];
  assign bus_done    = psel && penable && pready && reg_hit(paddr);
  assign field_x     = field.x;

  // =========================================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered after one wait state");

  a_chan_write: assert property (
    psel && penable && pready && pwrite && paddr[9:2] == IDX_CHAN && paddr[1:0] == 2'h0 &&
    paddr[ADDR_W-1:10] == '0 |=> st.chan == $past(chan_wdata))
    else $error("channel enables not taken from write data");

  a_chan_default: assert property ($rose(presetn) |-> st.chan == CHAN_RESET)
    else $error("channels not all enabled after reset");

  a_duty_enter: assert property (
    st.phase == PH_ACTIVE && st.count == 32'h0 && st.mode == MODE_DUTY |=> st.phase == PH_INACTIVE)
    else $error("duty mode did not enter inactive phase after burst");

  a_wait_load: assert property (
    st.phase == PH_ACTIVE && st.count == 32'h0 && st.mode == MODE_DUTY && st.inact == 3'h0
    |=> st.count == 32'(INACTIVE_US[0] * CYCLES_PER_US - 1))
    else $error("inactive wait for code 0 not 500 us");

  a_burst_len: assert property (
    st.phase == PH_IDLE && run && st.bw == 3'h0 && chan_count(st.chan) == 2'h2
    |=> st.count == 32'(ACTIVE_US[0][1] * CYCLES_PER_US - 1))
    else $error("two channel code 0 burst not 390 us");

  a_fir_flag: assert property (st.bw == 3'h0 |-> fir && burst_cycles(st.bw, st.chan) >=
    burst_cycles(3'h4, st.chan))
    else $error("code 0 not the filtered slowest setting");

  a_sleep_halt: assert property (st.mode == MODE_SLEEP |=> st.phase == PH_IDLE && $stable(st.data))
    else $error("sleep mode still converting");

  a_over_irq: assert property (
    st.phase == PH_ACTIVE && st.count == 32'h0 && run && over && st.mask[ST_OVER] |=> irq)
    else $error("field over threshold did not raise interrupt");

  a_repeat: assert property (
    st.phase == PH_INACTIVE && st.count == 32'h0 && st.mode == MODE_DUTY |=> st.phase == PH_ACTIVE)
    else $error("duty cycle did not resume a burst");

  a_ready_pulse: assert property (pready |=> !pready)
    else $error("apb ready held for more than one cycle");

  a_error_addr: assert property (psel && penable && pready && !reg_hit(paddr) |-> pslverr && prdata == '0)
    else $error("unmapped access not answered with error and zero data");

  a_mode_write: assert property (
    bus_done && pwrite && bus_idx == IDX_MODE |=> st.mode == mode_type'($past(mode_wdata)))
    else $error("mode field not taken from write data");

  a_inact_write: assert property (
    bus_done && pwrite && bus_idx == IDX_MODE |=> st.inact == $past(inact_wdata))
    else $error("inactive code not taken from write data");

  a_reset_idle: assert property ($rose(presetn) |-> st.phase == PH_IDLE && st.mode == MODE_ACTIVE && !irq)
    else $error("core not idle in active mode after reset");

  a_active_start: assert property (st.phase == PH_IDLE && st.mode == MODE_ACTIVE |=> st.phase == PH_ACTIVE)
    else $error("active mode did not start a burst");

  a_active_back: assert property (
    st.phase == PH_ACTIVE && st.count == 32'h0 && st.mode == MODE_ACTIVE |=> st.phase == PH_ACTIVE)
    else $error("active mode bursts not back to back");

  a_halt_idle: assert property (st.mode != MODE_ACTIVE && st.mode != MODE_DUTY |=> st.phase == PH_IDLE)
    else $error("halted mode still scheduling");

  a_core_class: assert property (
    bus_done && !pwrite && bus_idx == IDX_CORE |-> prdata[CORE_FIR] == (st.bw < BW_UNDEF_A) &&
    prdata[CORE_UNDEF] == (st.bw == BW_UNDEF_A || st.bw == BW_UNDEF_B))
    else $error("bandwidth class flags wrong on readback");

  a_unfiltered: assert property (st.bw > BW_UNDEF_A && st.bw < BW_UNDEF_B |-> !fir)
    else $error("codes 4 to 6 flagged as filtered");

  a_wait_count: assert property (
    st.phase == PH_INACTIVE && st.count != 32'h0 && st.mode == MODE_DUTY
    |=> st.phase == PH_INACTIVE && st.count == $past(st.count) - 32'h1)
    else $error("inactive wait not counting down");

  a_status_clear: assert property (
    bus_done && pwrite && bus_idx == IDX_STATUS && pwdata[ST_OVER] && !stat_set[ST_OVER]
    |=> !st.status[ST_OVER])
    else $error("over threshold flag not cleared by writing one");

  a_set_wins: assert property (stat_set[ST_UPDATE] |=> st.status[ST_UPDATE])
    else $error("data update flag lost");

  a_data_hold: assert property (st.phase != PH_ACTIVE |=> $stable(st.data))
    else $error("data changed outside a burst");

  a_axis_x: assert property (
    st.phase == PH_ACTIVE && st.count == 32'h0 && run && st.chan[0] |=> st.data.x == $past(field_x))
    else $error("enabled x axis not updated at burst end");

  a_axis_z_off: assert property (
    st.phase == PH_ACTIVE && st.count == 32'h0 && !st.chan[2] |=> $stable(st.data.z))
    else $error("disabled z axis updated");

  c_duty_cycle: cover property (st.phase == PH_ACTIVE ##1 st.phase == PH_INACTIVE ##[1:1000] st.phase == PH_ACTIVE);
  c_irq_raise:  cover property ($rose(irq));
  c_bus_in_wait: cover property (st.phase == PH_INACTIVE && psel && penable && pready && pwrite);
  c_bad_addr:   cover property (pready && pslverr);

endmodule

// ---- test/field_source.sv ----
// front-end model that feeds field samples to the sensor core
module field_source
  import sensor_duty_pkg::*;
(
  input  wire logic [15:0] base,  // sample value chosen by the bench
  output field_sample_type field  // samples into the core
);
  timeunit 1ns;
  timeprecision 100ps;
  // axes differ so a swapped axis cannot pass
  assign field = '{x: base, y: ~base, z: base ^ 16'h00FF};
endmodule

// ---- test/tb_top.sv ----
// self-checking bench for the duty-cycle power controller
module tb_top
  import sensor_duty_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              irq;
  logic              converting;
  logic [15:0]       base;
  field_sample_type  field;
  logic [31:0]       rd;
  logic              err;
  int                nlo;
  int                nhi;
  int                miscompares;
  int                samples_checked;

  // =========================================================================
  // design and front-end
  sensor_duty_ctrl #(.CYCLES_PER_US(1)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .field(field), .irq(irq), .converting(converting));
  field_source u_src (.base(base), .field(field));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // =========================================================================
  // reporting
  task automatic finish_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic stop(input string msg);
    miscompares++;
    $display("[FAIL] %0t %s", $time, msg);
    finish_test();
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s: got %0h want %0h", $time, msg, seen, exp);
    end
  endtask

  // =========================================================================
  // apb master; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) stop("no pready");
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input string msg);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp, msg);
  endtask

  // =========================================================================
  // phase timing, sampled on the falling edge where outputs are settled
  task automatic wait_lvl(input logic v, input int lim);
    int n;
    n = 0;
    while (converting !== v) begin
      @(negedge pclk);
      n++;
      if (n > lim) stop("phase stuck");
    end
  endtask

  task automatic run(input logic v, output int n);
    n = 0;
    while (converting === v) begin
      @(negedge pclk);
      n++;
      if (n > 30000) stop("phase too long");
    end
  endtask

  // one full duty period after the current one, so new settings are in force
  task automatic cycle(input int hi, input int lo, input string msg);
    wait_lvl(1'b1, 30000);
    wait_lvl(1'b0, 30000);
    run(1'b0, nlo);
    run(1'b1, nhi);
    chk(nlo, lo, msg);
    chk(nhi, hi, msg);
  endtask

  initial begin
    repeat (90000) @(posedge pclk);
    stop("watchdog");
  end

  // =========================================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    base = 16'h0000;
    miscompares = 0;
    samples_checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(IDX_CHAN, 32'h0000_01C0, "chan reset");
    rdc(IDX_MODE, 32'h0, "mode reset");
    rdc(IDX_MASK, 32'h0, "mask reset");
    rdc(IDX_THRESH, 32'h0000_7FFF, "thresh reset");
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1'b1, "unmapped error");
    // x and y only, most filtered code, shortest wait
    wr(IDX_CHAN, 32'h0000_00C0);
    wr(IDX_MODE, 32'h0000_0002);
    rdc(IDX_MODE, 32'h0000_0002, "mode readback");
    cycle(390, 500, "duty two axes");
    rdc(IDX_CORE, 32'h0000_0007, "core while inactive");
    base <= 16'h1234;
    wr(IDX_THRESH, 32'h0000_1000);
    wr(IDX_STATUS, 32'h0000_0003);
    wr(IDX_MASK, 32'h0000_0002);
    wait_lvl(1'b1, 1000);
    wait_lvl(1'b0, 1000);
    @(negedge pclk);
    chk(irq, 1'b1, "irq on over");
    rdc(IDX_STATUS, 32'h0000_0003, "status set");
    rdc(IDX_DATA_X, 32'h0000_1234, "data x");
    rdc(IDX_DATA_Y, 32'h0000_EDCB, "data y");
    rdc(IDX_DATA_Z, 32'h0000_0000, "disabled z kept");
    wr(IDX_STATUS, 32'h0000_0002);
    repeat (2) @(negedge pclk);
    chk(irq, 1'b0, "irq cleared");
    wr(IDX_MASK, 32'h0000_0000);
    wait_lvl(1'b1, 1000);
    wait_lvl(1'b0, 1000);
    @(negedge pclk);
    chk(irq, 1'b0, "irq masked");
    rdc(IDX_STATUS, 32'h0000_0003, "status while masked");
    // every bandwidth code, one axis; 3 and 7 timed like 6
    for (int k = 0; k < 8; k++) begin
      wr(IDX_CHAN, 32'h0000_0040 | k);
      cycle(ACTIVE_US[(k % 4 == 3) ? 6 : k][0], 500, "bw burst");
      rdc(IDX_CORE, {28'h0, k % 4 == 3, k < 3, 2'b11}, "bw class");
    end
    wr(IDX_CHAN, 32'h0000_00C0);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_MODE, 32'h2 | (c << 4));
      cycle(390, INACTIVE_US[c], "inactive code");
    end
    // sleep stops bursts and data updates
    wr(IDX_MODE, 32'h0000_0001);
    base <= 16'h0055;
    nhi = 0;
    repeat (2000) begin
      @(negedge pclk);
      nhi += (converting !== 1'b0);
    end
    chk(nhi, 0, "sleep bursts");
    rdc(IDX_DATA_X, 32'h0000_1234, "sleep data");
    wr(IDX_MODE, 32'h0000_0000);
    wait_lvl(1'b1, 4);
    repeat (400) @(negedge pclk);
    rdc(IDX_DATA_X, 32'h0000_0055, "active data");
    // mode 3 halts like sleep; the running burst ends one edge later
    wr(IDX_MODE, 32'h0000_0003);
    wait_lvl(1'b0, 4);
    nhi = 0;
    repeat (200) begin
      @(negedge pclk);
      nhi += (converting !== 1'b0);
    end
    chk(nhi, 0, "halt bursts");
    // reset in mid-run must restore the reset enables, all three axes on, not the ones that were written
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(IDX_CHAN, 32'h0000_01C0, "chan after reset");
    rdc(IDX_MODE, 32'h0, "mode after reset");
    chk(converting, 1'b1, "active after reset");
    finish_test();
  end
endmodule
